// [shared/pwr_reset_pkg.sv]
package pwr_reset_pkg;
    // opcodes carried over the command byte
    localparam logic [7:0] OP_DEEP_POWER_DOWN = 8'hB9;
    localparam logic [7:0] OP_RELEASE = 8'hAB;
    localparam logic [7:0] OP_SOFT_RESET = 8'hF0;
    // register bit positions
    localparam int WRITE_IN_PROGRESS_BIT = 0;
    localparam int QUAD_EN_BIT = 1;
    localparam int RESET_FEAT_BIT = 5;
    // device clock (link clock) and host clock periods in ps
    localparam int LINK_PERIOD_PS = 15000;
    localparam int HOST_PERIOD_PS = 40000;
    // times in ns
    localparam int CS_HIGH_READ_NS = 10;
    localparam int CS_HIGH_EXT_NS = 20;
    localparam int CS_HIGH_PROG_NS = 50;
    localparam int RESET_PULSE_WIDTH_NS = 200;
    localparam int RESET_SETUP_TIME_NS = 50;
    localparam int RESET_HOLD_TIME_NS = 50;
    // times in us
    localparam int RESET_COMPLETION_TIME_US = 35;
    localparam int RELEASE_DELAY_US = 30;
    localparam int POWER_UP_DELAY_US = 300;
    // device-side cycle counts (least times round up)
    localparam int CS_HIGH_READ_CYC = (CS_HIGH_READ_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int CS_HIGH_EXT_CYC = (CS_HIGH_EXT_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int RESET_PULSE_CYC =
        (RESET_PULSE_WIDTH_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int RESET_COMPLETION_CYC =
        (RESET_COMPLETION_TIME_US * 1000000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int RELEASE_DELAY_CYC =
        (RELEASE_DELAY_US * 1000000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int POWER_UP_CYC =
        (POWER_UP_DELAY_US * 1000000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    // host-side cycle counts
    localparam int H_CS_HIGH_PROG_CYC =
        (CS_HIGH_PROG_NS * 1000 + HOST_PERIOD_PS - 1) / HOST_PERIOD_PS;
    localparam int H_RESET_PULSE_CYC =
        (RESET_PULSE_WIDTH_NS * 1000 + HOST_PERIOD_PS - 1) / HOST_PERIOD_PS + 1;
    localparam int H_RESET_SETUP_CYC =
        (RESET_SETUP_TIME_NS * 1000 + HOST_PERIOD_PS - 1) / HOST_PERIOD_PS;
    localparam int H_RESET_HOLD_CYC =
        (RESET_HOLD_TIME_NS * 1000 + HOST_PERIOD_PS - 1) / HOST_PERIOD_PS;
    localparam int H_RESET_COMPLETION_CYC =
        (RESET_COMPLETION_TIME_US * 1000000 + HOST_PERIOD_PS - 1) / HOST_PERIOD_PS;
    localparam int H_POWER_UP_CYC =
        (POWER_UP_DELAY_US * 1000000 + HOST_PERIOD_PS - 1) / HOST_PERIOD_PS;
    localparam int H_RELEASE_CYC =
        (RELEASE_DELAY_US * 1000000 + HOST_PERIOD_PS - 1) / HOST_PERIOD_PS;
    localparam int SCK_DIV = 2;
    // reset values
    localparam logic [7:0] STATUS_ONE_RESET = 8'h00;
    localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
    localparam logic [7:0] CONFIG_TWO_RESET = 8'h00;
    // device power states
    typedef enum logic [2:0] {
        PS_POR, PS_RESET_HOLD, PS_HW_RESET, PS_STANDBY, PS_ACTIVE, PS_DEEP, PS_RELEASE
    } power_state_t;
endpackage

// [shared/flash_link_if.sv]
`timescale 1ns/100ps
interface flash_link_if;
    // chip select (active low) and serial clock, driven by the host
    logic cs_n;
    logic sck;
    // serial command in
    logic si;
    // shared fourth-data/reset pin, both ends may drive
    logic dq3_host_o;
    logic dq3_host_oe;
    logic dq3_dev_o;
    logic dq3_dev_oe;
    logic shared_dq3_reset_pin;
    // wire level: pull-up when nobody drives
    assign shared_dq3_reset_pin = dq3_dev_oe ? dq3_dev_o : (dq3_host_oe ? dq3_host_o : 1'b1);
    modport device (input cs_n, input sck, input si, input shared_dq3_reset_pin,
        output dq3_dev_o, output dq3_dev_oe);
    modport host (output cs_n, output sck, output si, output dq3_host_o, output dq3_host_oe,
        input shared_dq3_reset_pin);
endinterface

// [hdl/sync2.sv]
`timescale 1ns/100ps
module sync2 (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // level in, level out
    input wire logic d,
    output logic q
);
    logic meta_q;
    // two-stage synchroniser, resets to high (idle level of lines)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b1;
            q <= 1'b1;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // sync2

// [hdl/flash_pwr_device.sv]
`timescale 1ns/100ps
// What this block does
// - active while selected, standby after work
// - opcode B9h enters deep power-down
// - deep power-down only when write-in-progress clear
// - deep power-down ignores all but ABh
// - power-on sequence runs for power-up delay
// - host stays deselected during power-up
// - pin is reset after cs-high time or non-quad
// - reset ignored during power-on; host waits
// - reset low at power-up end holds reset
// - host holds reset high before next pulse
// - in quad mode, pin ignored within cs-high time
// - pulse over 200 ns gives warm reset
// - bad power-on makes pulse restart full sequence
// - reset instruction gives software reset
// - warm reset aborts, tri-states, ignores commands
// - device drives pin high after quad reads
// - host drives pin high after quad writes
// - host returns cs high during reset
// - host keeps cs high 50 ns after every frame
// - reset feature with quad extends cs-high
module flash_pwr_device
    import pwr_reset_pkg::*;
#(
    parameter int POWER_UP_CYCLES = POWER_UP_CYC,
    parameter int RESET_DONE_CYCLES = RESET_COMPLETION_CYC,
    parameter int RELEASE_CYCLES = RELEASE_DELAY_CYC
) (
    // link clock and power-on reset
    input wire logic link_clk,
    input wire logic rst,
    input wire logic ce,
    // link to host
    flash_link_if.device link,
    // core side
    input wire logic op_busy,
    input wire logic quad_read_done,
    input wire logic por_fault,
    input wire logic [7:0] config_one_in,
    input wire logic [7:0] config_two_in,
    output logic [2:0] power_state,
    output logic soft_reset_pulse,
    output logic regs_restore_pulse,
    output logic outputs_off
);
    ////////////////////////////////////////////////////////////////
    power_state_t st_q, st_d;
    logic cs_n_s, dq3_s, sck_s, si_s, sck_d1_q;
    logic [23:0] cnt_q;
    logic [7:0] cs_hi_cnt_q, rst_lo_cnt_q, shift_q;
    logic [2:0] bit_q;
    logic [7:0] config_one_q, config_two_q;
    logic drive_hi_q, drv_pending_q, soft_q, restore_q, por_ok_q;
    logic [3:0] pin_raw, pin_s;
    // synchronise pins into the link domain; cs_n and the reset pin idle high, sck and si need not,
    // which the edge detector below allows for in its own reset value
    assign pin_raw = {link.cs_n, link.shared_dq3_reset_pin, link.sck, link.si};
    generate
        for (genvar g = 0; g < 4; g++) begin : g_sync
            sync2 sync2_i (
                .clk(link_clk),
                .rst(rst),
                .ce(ce),
                .d(pin_raw[g]),
                .q(pin_s[g])
            );
        end
    endgenerate
    // pins in sampled form, named for the logic below
    assign cs_n_s = pin_s[3];
    assign dq3_s = pin_s[2];
    assign sck_s = pin_s[1];
    assign si_s = pin_s[0];
    ////////////////////////////////////////////////////////////////
    // decode
    wire quad_en = config_one_q[QUAD_EN_BIT];
    wire ext_cs = quad_en & config_two_q[RESET_FEAT_BIT];
    wire [7:0] cs_high_need = ext_cs ? 8'(CS_HIGH_EXT_CYC) : 8'(CS_HIGH_READ_CYC);
    wire cs_high_done = cs_hi_cnt_q >= cs_high_need;
    wire pin_is_reset = (cs_n_s & cs_high_done) | ~quad_en;
    wire reset_low = pin_is_reset & ~dq3_s;
    wire pulse_ok = rst_lo_cnt_q >= 8'(RESET_PULSE_CYC);
    wire sck_rise = sck_s & ~sck_d1_q;
    wire byte_done = sck_rise & ~cs_n_s & (bit_q == 3'h7);
    wire [7:0] cmd = {shift_q[6:0], si_s};
    wire cnt_zero = cnt_q == 24'h000000;
    wire hw_trigger = reset_low & pulse_ok;
    wire write_in_progress = op_busy; // status_one_volatile bit WRITE_IN_PROGRESS_BIT
    // true at the edge on which the machine moves from cur into state s
    function automatic logic entering(input power_state_t s, input power_state_t cur,
        input power_state_t nxt);
        entering = (nxt != cur) && (nxt == s);
    endfunction
    // one-cycle strobes on entry to the timed states, so each delay loads once
    wire enter_por = entering(PS_POR, st_q, st_d);
    wire enter_hw_reset = entering(PS_HW_RESET, st_q, st_d);
    wire enter_release = entering(PS_RELEASE, st_q, st_d);
    ////////////////////////////////////////////////////////////////
    // next power state
    always_comb begin
        st_d = st_q;
        case (st_q)
            PS_POR: if (cnt_zero) st_d = dq3_s ? PS_STANDBY : PS_RESET_HOLD;
            PS_RESET_HOLD: if (dq3_s) st_d = PS_STANDBY;
            PS_HW_RESET: if (cnt_zero) st_d = PS_STANDBY;
            PS_STANDBY: if (~cs_n_s) st_d = PS_ACTIVE;
            PS_ACTIVE: begin
                // deep power-down is refused while work is pending; the frame ends here
                if (byte_done && cmd == OP_DEEP_POWER_DOWN && !write_in_progress) begin
                    st_d = PS_DEEP;
                end else if (cs_n_s && !write_in_progress) begin
                    st_d = PS_STANDBY;
                end
            end
            PS_DEEP: if (byte_done && cmd == OP_RELEASE) st_d = PS_RELEASE;
            PS_RELEASE: if (cnt_zero) st_d = PS_STANDBY;
            default: st_d = PS_POR;
        endcase
        // a long enough low on the pin overrides whatever the machine was doing, except in PS_POR and PS_RESET_HOLD
        if (st_q != PS_POR && st_q != PS_RESET_HOLD && hw_trigger) begin
            st_d = por_ok_q ? PS_HW_RESET : PS_POR;
        end
    end
    ////////////////////////////////////////////////////////////////
    // state and delay counter
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            st_q <= PS_POR;
            cnt_q <= 24'(POWER_UP_CYCLES);
        end else if (ce) begin
            st_q <= st_d;
            if (enter_por) cnt_q <= 24'(POWER_UP_CYCLES);
            else if (enter_hw_reset) cnt_q <= 24'(RESET_DONE_CYCLES);
            else if (enter_release) cnt_q <= 24'(RELEASE_CYCLES);
            else if (!cnt_zero) cnt_q <= cnt_q - 24'h000001;
        end
    end
    // chip-select high and reset-low width counters
    // both saturate, so a long deselect or a long pulse never wraps
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            cs_hi_cnt_q <= 8'h00;
            rst_lo_cnt_q <= 8'h00;
        end else if (ce) begin
            cs_hi_cnt_q <= !cs_n_s ? 8'h00 : (cs_high_done ? cs_hi_cnt_q : cs_hi_cnt_q + 8'h01);
            if (!reset_low || st_q == PS_POR) rst_lo_cnt_q <= 8'h00;
            else if (!pulse_ok) rst_lo_cnt_q <= rst_lo_cnt_q + 8'h01;
        end
    end
    // command shifter, sampled on serial clock rising edges
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            sck_d1_q <= 1'b1; // matches the synchroniser reset, no false edge
            shift_q <= 8'h00;
            bit_q <= 3'h0;
        end else if (ce) begin
            sck_d1_q <= sck_s;
            if (cs_n_s || st_q == PS_HW_RESET || st_q == PS_POR) bit_q <= 3'h0;
            else if (sck_rise) begin
                shift_q <= cmd;
                bit_q <= bit_q + 3'h1;
            end
        end
    end
    // volatile config capture, restore and soft reset
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            config_one_q <= CONFIG_ONE_RESET;
            config_two_q <= CONFIG_TWO_RESET;
            soft_q <= 1'b0;
            restore_q <= 1'b0;
            por_ok_q <= 1'b0;
        end else if (ce) begin
            soft_q <= byte_done && cmd == OP_SOFT_RESET && dq3_s &&
                (st_q == PS_ACTIVE);
            restore_q <= enter_hw_reset;
            if (st_q == PS_POR && cnt_zero) por_ok_q <= ~por_fault;
            if (st_d == PS_HW_RESET || st_d == PS_POR || soft_q) begin
                config_one_q <= CONFIG_ONE_RESET;
                config_two_q <= CONFIG_TWO_RESET;
            end else if (st_q == PS_STANDBY) begin
                config_one_q <= config_one_in;
                config_two_q <= config_two_in;
            end
        end
    end
    // pin drive after quad reads, during the cs-high time
    // the drive lasts only the cs-high window, then the pull-up takes over
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            drv_pending_q <= 1'b0;
            drive_hi_q <= 1'b0;
        end else if (ce) begin
            if (quad_read_done && quad_en) drv_pending_q <= 1'b1;
            else if (cs_n_s && cs_high_done) drv_pending_q <= 1'b0;
            drive_hi_q <= drv_pending_q & cs_n_s & ~cs_high_done &
                (st_q != PS_HW_RESET);
        end
    end
    // outputs from flops, except dq3_dev_o which is tied high
    assign link.dq3_dev_o = 1'b1;
    assign link.dq3_dev_oe = drive_hi_q;
    assign power_state = st_q;
    assign soft_reset_pulse = soft_q;
    assign regs_restore_pulse = restore_q;
    // taken from the next state so the outputs float on the entry edge itself
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) outputs_off <= 1'b1;
        else if (ce) outputs_off <= (st_d == PS_HW_RESET) || (st_d == PS_POR);
    end
endmodule // flash_pwr_device

// [hdl/flash_pwr_host.sv]
`timescale 1ns/100ps
module flash_pwr_host
    import pwr_reset_pkg::*;
#(
    parameter int POWER_UP_CYCLES = H_POWER_UP_CYC,
    parameter int RESET_DONE_CYCLES = H_RESET_COMPLETION_CYC,
    parameter int RELEASE_CYCLES = H_RELEASE_CYC
) (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // link to device
    flash_link_if.host link,
    // user side
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic hw_reset_req,
    input wire logic quad_write_done,
    output logic ready,
    output logic cmd_done
);
    typedef enum logic [2:0] {H_PWRUP, H_IDLE, H_SHIFT, H_GAP, H_RST_LOW, H_RST_WAIT}
        host_state_t;
    host_state_t st_q;
    logic [23:0] cnt_q;
    logic [7:0] sh_q;
    logic [3:0] bits_q;
    logic sck_q, cs_n_q, rst_drv_q, hi_drv_q;
    // counter idle, and the command that asks for the release wait
    wire cnt_zero = cnt_q == 24'h000000;
    wire wait_release = sh_q == OP_RELEASE;
    // host sequencer, serial clock divided from clk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= H_PWRUP;
            cnt_q <= 24'(POWER_UP_CYCLES);
            sh_q <= 8'h00;
            bits_q <= 4'h0;
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
            rst_drv_q <= 1'b0;
            hi_drv_q <= 1'b0;
            ready <= 1'b0;
            cmd_done <= 1'b0;
        end else if (ce) begin
            cmd_done <= 1'b0;
            if (!cnt_zero) cnt_q <= cnt_q - 24'h000001;
            case (st_q)
                H_PWRUP: if (cnt_zero) begin
                    st_q <= H_IDLE;
                    ready <= 1'b1;
                end
                H_IDLE: begin
                    hi_drv_q <= 1'b0;
                    ready <= cnt_zero; // offered only once any pending wait has run out
                    if (hw_reset_req && cnt_zero) begin
                        st_q <= H_RST_LOW;
                        cs_n_q <= 1'b1;
                        rst_drv_q <= 1'b1;
                        ready <= 1'b0;
                        cnt_q <= 24'(H_RESET_PULSE_CYC);
                    end else if (cmd_valid && cnt_zero) begin
                        st_q <= H_SHIFT;
                        sh_q <= cmd_byte;
                        bits_q <= 4'h0;
                        cs_n_q <= 1'b0;
                        ready <= 1'b0;
                    end
                end
                H_SHIFT: begin
                    sck_q <= ~sck_q;
                    if (sck_q) begin
                        sh_q <= {sh_q[6:0], sh_q[7]};
                        bits_q <= bits_q + 4'h1;
                        if (bits_q == 4'h7) begin
                            st_q <= H_GAP;
                            cs_n_q <= 1'b1;
                            cnt_q <= 24'(H_CS_HIGH_PROG_CYC);
                            hi_drv_q <= quad_write_done;
                        end
                    end
                end
                H_GAP: if (cnt_zero) begin
                    hi_drv_q <= 1'b0;
                    st_q <= H_IDLE;
                    ready <= ~wait_release;
                    cmd_done <= 1'b1;
                    if (wait_release) cnt_q <= 24'(RELEASE_CYCLES);
                end
                H_RST_LOW: if (cnt_zero) begin
                    rst_drv_q <= 1'b0;
                    st_q <= H_RST_WAIT;
                    cnt_q <= 24'(RESET_DONE_CYCLES);
                end
                H_RST_WAIT: if (cnt_zero) begin
                    st_q <= H_IDLE;
                    ready <= 1'b0;
                    cnt_q <= 24'(H_RESET_HOLD_CYC + H_RESET_SETUP_CYC);
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
    // pin drive: low for reset, high after quad writes
    assign link.cs_n = cs_n_q;
    assign link.sck = sck_q;
    assign link.si = sh_q[7];
    assign link.dq3_host_o = ~rst_drv_q;
    assign link.dq3_host_oe = rst_drv_q | hi_drv_q;
endmodule // flash_pwr_host

// [bench/flash_pwr_chk.sv]
`timescale 1ns/100ps
module flash_pwr_chk #(
    parameter int POWER_UP_CYCLES = 50
) (
    // clocks and reset
    input wire logic clk,
    input wire logic link_clk,
    input wire logic rst,
    // link signals
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic dq3_host_o,
    input wire logic dq3_host_oe,
    input wire logic dq3_dev_o,
    input wire logic dq3_dev_oe,
    input wire logic shared_dq3_reset_pin
);
    logic [15:0] pu_q;
    logic [3:0] bits_q;
    logic sck_q;
    logic host_low;
    ////////////////////////////////////////////////////////////////////////////////
    // host pulling the shared pin low
    assign host_low = dq3_host_oe & ~dq3_host_o;
    // power-up age and serial clock rises per frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pu_q <= 16'h0;
            bits_q <= 4'h0;
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck;
            if (pu_q < 16'(POWER_UP_CYCLES)) pu_q <= pu_q + 16'h1;
            if (cs_n) bits_q <= 4'h0;
            else if (sck && !sck_q) bits_q <= bits_q + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_powerup_desel: assert property (@(posedge clk) disable iff (rst)
        pu_q < 16'(POWER_UP_CYCLES) |-> cs_n) else $error("select during power-up");
    a_frame_eight: assert property (@(posedge clk) disable iff (rst)
        $rose(cs_n) |-> bits_q == 4'h8) else $error("frame not eight bits");
    a_gap_after_frame: assert property (@(posedge clk) disable iff (rst)
        $rose(cs_n) |-> cs_n [*2]) else $error("select gap too short");
    a_reset_desel: assert property (@(posedge clk) disable iff (rst)
        !shared_dq3_reset_pin |-> cs_n) else $error("select while reset low");
    a_reset_hold: assert property (@(posedge clk) disable iff (rst)
        $rose(shared_dq3_reset_pin) |-> cs_n [*2]) else $error("select too soon after reset");
    a_pulse_width: assert property (@(posedge clk) disable iff (rst)
        $rose(host_low) |-> host_low [*6]) else $error("reset pulse too short");
    a_no_low_in_gap: assert property (@(posedge clk) disable iff (rst)
        host_low |-> cs_n && $past(cs_n, 2)) else $error("host low inside select gap");
    a_dev_drive_high: assert property (@(posedge link_clk) disable iff (rst)
        dq3_dev_oe |-> dq3_dev_o && cs_n) else $error("device drives shared pin badly");
endmodule // flash_pwr_chk

// [bench/test_flash_power_mode_reset_ctrl.sv]
`timescale 1ns/100ps
module test_flash_power_mode_reset_ctrl import pwr_reset_pkg::*;;
    localparam int PU = 50;
    localparam int RD = 40;
    localparam int RL = 30;
    logic clk = 1'b0, link_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, hw_reset_req = 1'b0;
    logic quad_write_done = 1'b0, op_busy = 1'b0, quad_read_done = 1'b0, por_fault = 1'b0;
    logic [7:0] cmd_byte = 8'h00, config_one = 8'h00, config_two = 8'h00;
    logic ready, cmd_done, soft_reset_pulse, regs_restore_pulse, outputs_off;
    logic [2:0] power_state;
    logic seen_soft = 1'b0, seen_restore = 1'b0, seen_drive = 1'b0, seen_host_hi = 1'b0;
    int n_mismatch = 0, n_tests = 0;
    ////////////////////////////////////////////////////////////////////////////////
    flash_link_if link ();
    flash_pwr_host #(.POWER_UP_CYCLES(PU), .RESET_DONE_CYCLES(RD), .RELEASE_CYCLES(RL))
        flash_pwr_host_i (.clk(clk), .rst(rst), .ce(1'b1), .link(link), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .hw_reset_req(hw_reset_req), .quad_write_done(quad_write_done),
        .ready(ready), .cmd_done(cmd_done));
    flash_pwr_device #(.POWER_UP_CYCLES(PU), .RESET_DONE_CYCLES(RD), .RELEASE_CYCLES(RL))
        flash_pwr_device_i (.link_clk(link_clk), .rst(rst), .ce(1'b1), .link(link),
        .op_busy(op_busy), .quad_read_done(quad_read_done), .por_fault(por_fault),
        .config_one_in(config_one), .config_two_in(config_two), .power_state(power_state),
        .soft_reset_pulse(soft_reset_pulse), .regs_restore_pulse(regs_restore_pulse),
        .outputs_off(outputs_off));
    flash_pwr_chk #(.POWER_UP_CYCLES(PU)) flash_pwr_chk_i (.clk(clk), .link_clk(link_clk),
        .rst(rst), .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .dq3_host_o(link.dq3_host_o),
        .dq3_host_oe(link.dq3_host_oe), .dq3_dev_o(link.dq3_dev_o),
        .dq3_dev_oe(link.dq3_dev_oe), .shared_dq3_reset_pin(link.shared_dq3_reset_pin));
    ////////////////////////////////////////////////////////////////////////////////
    // host clock and an unrelated link clock
    always #20 clk = ~clk;
    initial begin
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    // sticky flags for short device and host pulses
    always @(negedge link_clk) begin
        if (soft_reset_pulse === 1'b1) seen_soft = 1'b1;
        if (regs_restore_pulse === 1'b1) seen_restore = 1'b1;
        if (link.dq3_dev_oe === 1'b1 && link.shared_dq3_reset_pin === 1'b1) seen_drive = 1'b1;
        if (link.dq3_host_oe === 1'b1 && link.dq3_host_o === 1'b1) seen_host_hi = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task complete_run();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("ready", 8'h01, {7'h00, ready});
        if (ready !== 1'b1) complete_run();
    endtask
    task wait_state(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        while (power_state !== s && n < lim) begin
            @(negedge link_clk);
            n++;
        end
        chk("power_state", {5'h00, s}, {5'h00, power_state});
        if (power_state !== s) complete_run();
        @(posedge clk);
        #1;
    endtask
    task send(input logic [7:0] op);
        int n;
        wait_ready(n);
        cmd_byte = op;
        cmd_valid = 1'b1;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        n = 0;
        while (cmd_done !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("cmd_done", 8'h01, {7'h00, cmd_done});
    endtask
    task hw_reset();
        int n;
        wait_ready(n);
        hw_reset_req = 1'b1;
        @(posedge clk);
        #1;
        hw_reset_req = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_power_up();
        int n;
        chk("ready", 8'h00, {7'h00, ready});
        chk("power_state", {5'h00, PS_POR}, {5'h00, power_state});
        wait_ready(n);
        chk("power_up_wait", 8'h01, {7'h00, n >= PU - 2});
        wait_state(PS_STANDBY, 10);
    endtask
    task t_active();
        op_busy = 1'b1;
        send(8'h05);
        repeat (10) @(negedge link_clk);
        chk("power_state", {5'h00, PS_ACTIVE}, {5'h00, power_state});
        op_busy = 1'b0;
        wait_state(PS_STANDBY, 20);
    endtask
    task t_deep();
        op_busy = 1'b1;
        send(OP_DEEP_POWER_DOWN);
        repeat (20) @(negedge link_clk);
        chk("deep_refused", 8'h00, {7'h00, power_state === PS_DEEP});
        op_busy = 1'b0;
        wait_state(PS_STANDBY, 20);
        send(OP_DEEP_POWER_DOWN);
        wait_state(PS_DEEP, 20);
        seen_soft = 1'b0;
        send(8'h05);
        send(OP_SOFT_RESET);
        repeat (20) @(negedge link_clk);
        chk("power_state", {5'h00, PS_DEEP}, {5'h00, power_state});
        chk("soft_in_deep", 8'h00, {7'h00, seen_soft});
        send(OP_RELEASE);
        wait_state(PS_RELEASE, 20);
        wait_state(PS_STANDBY, RL + 20);
    endtask
    task t_soft();
        seen_soft = 1'b0;
        send(OP_SOFT_RESET);
        repeat (20) @(negedge link_clk);
        chk("soft_reset", 8'h01, {7'h00, seen_soft});
    endtask
    task t_quad();
        config_one = 8'h02;
        repeat (5) @(posedge clk);
        #1;
        seen_drive = 1'b0;
        seen_host_hi = 1'b0;
        quad_read_done = 1'b1;
        quad_write_done = 1'b1;
        send(8'h6B);
        quad_read_done = 1'b0;
        quad_write_done = 1'b0;
        repeat (10) @(negedge link_clk);
        chk("device_drive_high", 8'h01, {7'h00, seen_drive});
        chk("host_drive_high", 8'h01, {7'h00, seen_host_hi});
        config_one = 8'h00;
    endtask
    task t_hw_reset();
        seen_restore = 1'b0;
        hw_reset();
        wait_state(PS_HW_RESET, 100);
        chk("outputs_off", 8'h01, {7'h00, outputs_off});
        wait_state(PS_STANDBY, RD + 300);
        chk("regs_restore", 8'h01, {7'h00, seen_restore});
        chk("outputs_off", 8'h00, {7'h00, outputs_off});
    endtask
    task t_por_fault();
        int n;
        por_fault = 1'b1;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        wait_ready(n);
        por_fault = 1'b0;
        hw_reset();
        wait_state(PS_POR, 100);
        wait_state(PS_STANDBY, PU + 300);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        t_power_up();
        t_active();
        t_deep();
        t_soft();
        t_quad();
        t_hw_reset();
        t_por_fault();
        complete_run();
    end
    // hang guard
    initial begin
        #500000;
        n_mismatch++;
        complete_run();
    end
endmodule // test_flash_power_mode_reset_ctrl
